// File: src/sysrst_pkg.sv
// Purpose: constants shared by the system reset and supply monitor block
// Assumes: 40 MHz mclk
// Notes:   thresholds are analog facts; the logic sees comparator flags
package sysrst_pkg;
  localparam int          CLK_MHZ        = 40;
  localparam int          WAKE_TIME_NS   = 1000;
  localparam int          WAKE_CYCLES    = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W          = 16;
  localparam logic [15:0] WAKE_COUNT     = 16'(WAKE_CYCLES);
  localparam logic [31:0] SECURE_WORD    = 32'h8765_4321;
  localparam logic [31:0] SECURE_ADDR    = 32'h0000_01fc;
  localparam logic [31:0] RESET_VEC_ADDR = 32'h0000_0000;
  localparam int          EDGE_INTS      = 50;
  localparam int          LEVEL_INTS     = 4;
  localparam int          EXT_INTS       = EDGE_INTS + LEVEL_INTS;

  typedef enum logic [1:0] {
    MAP_BOOT = 2'h0,
    MAP_SRAM = 2'h1,
    MAP_EXT  = 2'h2
  } vecmap_t;

  typedef enum logic [2:0] {
    ST_HOLD    = 3'h0,
    ST_COUNT   = 3'h1,
    ST_FLASH   = 3'h2,
    ST_SECCHK  = 3'h3,
    ST_RUN     = 3'h4
  } rststate_t;
endpackage : sysrst_pkg

// File: src/sync2.sv
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: inputs are quasi-static levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule : sync2
`default_nettype wire

// File: src/system_reset_and_supply_monitor.sv
// Purpose: system reset sequencing, supply droop handling, code security,
//          vector mapping and external interrupt wake-up
// Assumes: reset is a synchronous power-on style input; analog flags async
// Notes:   resetReqN asserts and releases combinationally; coreResetN release is clocked
// Contract
// R1: chip reset asserts on pin, watchdog, power-on or droop request.
// R2: any reset restarts wake timer; release waits pin, osc, count, flash.
// R3: after release fetch begins at address zero showing boot vector.
// R4: registers hold reset values by release; reset held until then.
// R5: below first threshold a droop warning request goes to interrupt ctrl.
// R6: warning gated by controller enable; level always readable as status.
// R7: below second threshold chip reset asserts and flash alteration blocks.
// R8: droop holds reset down to about 1 V, then power-on takes over.
// R9: both droop thresholds have hysteresis, keeping the warning stable.
// R10: valid checksum and security word at 0x1fc disable debug access.
// R11: debug re-enabled only by full chip erase through in-system programming; the reset input also clears security here.
// R12: mapping control selects vectors from boot ROM, SRAM or external memory.
// R13: up to 50 edge and four level external interrupt inputs.
// R14: configured external interrupt wakes processor from deep retained state.
// R15: wake timer lets code run only once oscillator is judged stable.
// R16: reset sources ORed, assert asynchronous, release synchronous to clock.
// R17: warning status follows synchronised first stage, read only.
`timescale 1ns/1ps
`default_nettype none
module system_reset_and_supply_monitor
  import sysrst_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      resetPinN,
  input  wire logic                      watchdogReq,
  input  wire logic                      powerOnReq,
  input  wire logic                      droopWarnRaw,
  input  wire logic                      droopResetRaw,
  input  wire logic                      oscStable,
  input  wire logic                      flashInitDone,
  input  wire logic                      checksumValid,
  input  wire logic [31:0]               secureWordData,
  input  wire logic                      chipEraseIsp,
  input  wire logic                      warnIntEnable,
  input  wire logic [1:0]                vecMapSel,
  input  wire logic [sysrst_pkg::EXT_INTS-1:0] extIntPins,
  input  wire logic [sysrst_pkg::EXT_INTS-1:0] extIntWakeEn,
  input  wire logic                      powerDown,
  output logic                           resetReqN,
  output logic                           coreResetN,
  output logic [31:0]                    fetchAddr,
  output logic [31:0]                    secureWordAddr,
  output logic                           droopWarnIrq,
  output logic                           droopWarnToCore,
  output logic                           droopWarnStatus,
  output logic                           flashWriteBlock,
  output logic                           debugEnable,
  output logic [1:0]                     vecMapActive,
  output logic [sysrst_pkg::EXT_INTS-1:0] extIntFlags,
  output logic                           wakeUp
);
  logic                resetPinSyncN;
  logic [6:0]          asyncSync;
  logic                anyReq;
  logic [EXT_INTS-1:0] pinSync;
  rststate_t           state_q, state_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic                coreRun_q, coreRun_d;
  logic                secure_q, secure_d;
  logic [1:0]          map_q, map_d;
  logic                warn_q, warn_d;
  logic [EXT_INTS-1:0] pinPrev_q, pinPrev_d;
  logic [EXT_INTS-1:0] flags_q, flags_d;
  logic                wake_q, wake_d;

  sync2 #(.W(7)) uSyncCtl (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn ({resetPinN, watchdogReq, droopWarnRaw, droopResetRaw,
               oscStable, flashInitDone, chipEraseIsp}),
    .syncOut (asyncSync)
  );

  sync2 #(.W(EXT_INTS)) uSyncPins (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn (extIntPins),
    .syncOut (pinSync)
  );

  assign resetPinSyncN = asyncSync[6];

  // the OR stays asynchronous so a dying supply resets without a clock
  assign anyReq    = ~resetPinN | watchdogReq | powerOnReq
                   | droopResetRaw; // R1 R7 R8 R16
  assign resetReqN = ~anyReq; // R16

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    coreRun_d = 1'b0;
    secure_d  = secure_q;
    map_d     = map_q;
    case (state_q)
      ST_HOLD: begin
        cnt_d = '0;
        if (resetPinSyncN && asyncSync[2])
          state_d = ST_COUNT; // R15
      end
      ST_COUNT: begin
        cnt_d = cnt_q + 16'h0001;
        if (!asyncSync[2])
          state_d = ST_HOLD; // R15
        else if (cnt_q >= WAKE_COUNT - 16'h0001)
          state_d = ST_FLASH; // R2
      end
      ST_FLASH: if (asyncSync[1]) state_d = ST_SECCHK; // R2
      ST_SECCHK: begin
        // R10: security word sampled once per boot
        if (checksumValid && secureWordData == SECURE_WORD)
          secure_d = 1'b1; // R10
        map_d   = MAP_BOOT; // R3
        state_d = ST_RUN;
      end
      ST_RUN: begin
        coreRun_d = 1'b1;
        // hold boot vectors until the core has run one cycle
        map_d     = coreRun_q ? vecMapSel : map_q; // R12
      end
      default: state_d = ST_HOLD;
    endcase
    if (asyncSync[0])
      secure_d = 1'b0; // R11
    if (anyReq || !resetPinSyncN || asyncSync[3] || asyncSync[5]) begin
      state_d   = ST_HOLD; // R2
      coreRun_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge anyReq) begin
    if (anyReq) begin
      state_q   <= ST_HOLD; // R16
      cnt_q     <= '0;
      coreRun_q <= 1'b0;
      map_q     <= MAP_BOOT; // R4
    end else if (reset) begin
      state_q   <= ST_HOLD;
      cnt_q     <= '0;
      coreRun_q <= 1'b0;
      map_q     <= MAP_BOOT;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      coreRun_q <= coreRun_d;
      map_q     <= map_d;
    end
  end

  // security survives pin, watchdog, power-on and droop resets; only erase or the reset input clears it
  always_ff @(posedge mclk) begin
    if (reset) secure_q <= 1'b0;
    else       secure_q <= secure_d; // R11
  end

  // R13 R14: edge detection on the 50 edge pins, level on the rest, wake only where enabled
  always_comb begin
    pinPrev_d = pinSync;
    warn_d    = asyncSync[4]; // R17
    wake_d    = 1'b0;
    flags_d   = flags_q;
    for (int i = 0; i < EXT_INTS; i++) begin
      if (i < EDGE_INTS)
        flags_d[i] = flags_q[i] | (pinSync[i] & ~pinPrev_q[i]); // R13
      else
        flags_d[i] = pinSync[i]; // R13
      if (powerDown && extIntWakeEn[i] && flags_d[i])
        wake_d = 1'b1; // R14
    end
    if (!coreRun_q)
      flags_d = '0;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pinPrev_q <= '0;
      warn_q    <= 1'b0;
      flags_q   <= '0;
      wake_q    <= 1'b0;
    end else begin
      pinPrev_q <= pinPrev_d;
      warn_q    <= warn_d;
      flags_q   <= flags_d;
      wake_q    <= wake_d;
    end
  end

  // hysteresis lives in the analog comparator; the sync keeps it clean R9
  assign coreResetN      = coreRun_q; // R4
  assign fetchAddr       = RESET_VEC_ADDR; // R3
  assign secureWordAddr  = SECURE_ADDR;
  assign droopWarnStatus = warn_q; // R6 R17
  assign droopWarnIrq    = warn_q; // R5
  assign droopWarnToCore = warn_q & warnIntEnable; // R6
  assign flashWriteBlock = ~coreRun_q | asyncSync[3]; // R7
  assign debugEnable     = ~secure_q & coreRun_q; // R10
  assign vecMapActive    = map_q;
  assign extIntFlags     = flags_q;
  assign wakeUp          = wake_q;

  AST_WARN_GATE: assert property (@(posedge mclk) disable iff (reset)
    droopWarnToCore |-> droopWarnStatus && warnIntEnable) // R6
    else $error("warning reached core while disabled");
  AST_WARN_FOLLOW: assert property (@(posedge mclk) disable iff (reset)
    $rose(asyncSync[4]) |=> droopWarnStatus) // R17
    else $error("warning status lags monitor");
  AST_RESET_HOLD: assert property (@(posedge mclk) disable iff (reset)
    !asyncSync[1] |-> ##1 !coreResetN) // R2
    else $error("core released before flash init");
  AST_RELEASE_SEQ: assert property (@(posedge mclk) disable iff (reset)
    $rose(coreResetN) |-> $past(state_q, 2) == ST_SECCHK) // R15
    else $error("release skipped sequence");
  AST_BOOT_MAP: assert property (@(posedge mclk) disable iff (reset)
    $rose(coreResetN) |-> vecMapActive == MAP_BOOT) // R3
    else $error("boot vectors not mapped at release");
  AST_SECURE: assert property (@(posedge mclk) disable iff (reset)
    secure_q && !asyncSync[0] |=> !debugEnable) // R10
    else $error("debug open while secured");
  AST_DROOP_BLOCK: assert property (@(posedge mclk) disable iff (reset)
    asyncSync[3] |-> flashWriteBlock) // R7
    else $error("flash writable during droop reset");
  AST_ANY_RESET: assert property (@(posedge mclk) disable iff (reset)
    anyReq |-> !resetReqN) // R1
    else $error("reset request not raised");
  AST_WAKE: assert property (@(posedge mclk) disable iff (reset)
    wakeUp |-> $past(powerDown)) // R14
    else $error("wake outside power-down");

  COV_RELEASE: cover property (@(posedge mclk) $rose(coreResetN));
  COV_WARN:    cover property (@(posedge mclk) $rose(droopWarnToCore));
  COV_SECURE:  cover property (@(posedge mclk) $rose(secure_q));
  COV_WAKE:    cover property (@(posedge mclk) wakeUp);
endmodule : system_reset_and_supply_monitor
`default_nettype wire

// File: testbench/core_side_model.sv
// Purpose: processor and interrupt controller side of the reset block
// Assumes: enable request comes from the bench, taken on the clock edge
// Notes:   the enable is a register, as software would program it
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
  input  wire logic mclk,
  input  wire logic coreResetN,
  input  wire logic droopWarnToCore,
  input  wire logic enReq,
  output var  logic warnIntEnable,
  output var  int   irqCnt
);
  initial warnIntEnable = 1'b0;
  initial irqCnt = 0;
  always @(posedge mclk) begin
    warnIntEnable <= enReq;
    // interrupts are taken only while the core runs
    if (coreResetN === 1'b1 && droopWarnToCore === 1'b1) irqCnt <= irqCnt + 1;
  end
endmodule : core_side_model
`default_nettype wire

// File: testbench/test_system_reset_and_supply_monitor.sv
// Purpose: self-checking bench for the system reset and supply monitor
// Assumes: inputs change at the falling edge of mclk
// Notes:   release timing is checked as a window, not an exact cycle
`timescale 1ns/1ps
`default_nettype none
module test_system_reset_and_supply_monitor;
  import sysrst_pkg::*;
  logic mclk = 0, reset = 1, resetPinN = 1, watchdogReq = 0, powerOnReq = 0;
  logic droopWarnRaw = 0, droopResetRaw = 0, oscStable = 1, flashInitDone = 1;
  logic checksumValid = 0, chipEraseIsp = 0, enReq = 0, powerDown = 0;
  logic [31:0] secureWordData = 0;
  logic [1:0]  vecMapSel = 0;
  logic [EXT_INTS-1:0] extIntPins = 0, extIntWakeEn = 0, extIntFlags;
  logic resetReqN, coreResetN, droopWarnIrq, droopWarnToCore, droopWarnStatus;
  logic flashWriteBlock, debugEnable, wakeUp, warnIntEnable;
  logic [31:0] fetchAddr, secureWordAddr;
  logic [1:0]  vecMapActive;
  int error_cnt = 0, num_checks = 0, n, b, irqCnt;

  system_reset_and_supply_monitor i_system_reset_and_supply_monitor (
    .mclk(mclk), .reset(reset), .resetPinN(resetPinN),
    .watchdogReq(watchdogReq), .powerOnReq(powerOnReq),
    .droopWarnRaw(droopWarnRaw), .droopResetRaw(droopResetRaw),
    .oscStable(oscStable), .flashInitDone(flashInitDone),
    .checksumValid(checksumValid), .secureWordData(secureWordData),
    .chipEraseIsp(chipEraseIsp), .warnIntEnable(warnIntEnable),
    .vecMapSel(vecMapSel), .extIntPins(extIntPins),
    .extIntWakeEn(extIntWakeEn), .powerDown(powerDown),
    .resetReqN(resetReqN), .coreResetN(coreResetN), .fetchAddr(fetchAddr),
    .secureWordAddr(secureWordAddr), .droopWarnIrq(droopWarnIrq),
    .droopWarnToCore(droopWarnToCore), .droopWarnStatus(droopWarnStatus),
    .flashWriteBlock(flashWriteBlock), .debugEnable(debugEnable),
    .vecMapActive(vecMapActive), .extIntFlags(extIntFlags), .wakeUp(wakeUp));
  core_side_model i_core_side_model (.mclk(mclk), .coreResetN(coreResetN),
    .droopWarnToCore(droopWarnToCore), .enReq(enReq),
    .warnIntEnable(warnIntEnable), .irqCnt(irqCnt));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // cycles until the core leaves reset, bounded
  task automatic boot(output int c);
    c = 0;
    while (coreResetN !== 1'b1 && c < 400) begin
      @(negedge mclk);
      c++;
    end
  endtask : boot

  task automatic pulse_wd();
    @(negedge mclk) watchdogReq = 1;
    repeat (3) @(negedge mclk);
    watchdogReq = 0;
    boot(n);
    chk("wdBoot", 1, n < 400);
  endtask : pulse_wd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial begin
    #(25ns * 6000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hb13edd55));
    flashInitDone = 0;
    repeat (3) @(negedge mclk);
    reset = 0;
    repeat (80) @(negedge mclk);
    chk("coreResetN flash pending", 0, coreResetN);
    flashInitDone = 1;
    boot(n);
    chk("bootTime", 1, n <= WAKE_CYCLES + 12);
    chk("fetchAddr", RESET_VEC_ADDR, fetchAddr);
    chk("vecMapActive", MAP_BOOT, vecMapActive);
    chk("debugEnable", 1, debugEnable);
    $display("test boot done");
    for (int s = 0; s < 4; s++) begin
      @(negedge mclk);
      {droopResetRaw, powerOnReq, watchdogReq, resetPinN} = 4'(1 << s) ^ 4'h1;
      #1 chk("resetReqN", 0, resetReqN);
      repeat (3) @(negedge mclk);
      chk("coreResetN", 0, coreResetN);
      if (s == 3) chk("flashWriteBlock", 1, flashWriteBlock);
      {droopResetRaw, powerOnReq, watchdogReq, resetPinN} = 4'h1;
      repeat (20) @(negedge mclk);
      if (s == 1) oscStable = 0;
      repeat (2) @(negedge mclk);
      oscStable = 1;
      boot(b);
      chk("srcRelease", 1, b + 22 >= WAKE_CYCLES + (s == 1 ? 22 : 3));
      chk("srcReleaseMax", 1, b + 22 <= WAKE_CYCLES + (s == 1 ? 36 : 14));
    end
    $display("test sources done");
    for (int e = 0; e < 2; e++) begin
      @(negedge mclk) enReq = e[0];
      droopWarnRaw = 1;
      repeat (4) @(negedge mclk);
      chk("droopWarnStatus", 1, droopWarnStatus);
      chk("droopWarnIrq", 1, droopWarnIrq);
      chk("droopWarnToCore", e, droopWarnToCore);
      chk("coreResetN warn", 1, coreResetN);
      droopWarnRaw = 0;
      repeat (4) @(negedge mclk);
      chk("droopWarnStatus off", 0, droopWarnStatus);
    end
    chk("irqTaken", 1, irqCnt > 0);
    $display("test droop warning done");
    for (int m = 0; m < 3; m++) begin
      @(negedge mclk) vecMapSel = 2'(m);
      repeat (3) @(negedge mclk);
      chk("vecMapActive", m, vecMapActive);
    end
    $display("test vector map done");
    checksumValid = 1;
    secureWordData = SECURE_WORD;
    pulse_wd();
    chk("secureWordAddr", SECURE_ADDR, secureWordAddr);
    chk("debugEnable locked", 0, debugEnable);
    secureWordData = ~SECURE_WORD;
    pulse_wd();
    chk("debugEnable sticky", 0, debugEnable);
    @(negedge mclk) chipEraseIsp = 1;
    repeat (3) @(negedge mclk);
    chipEraseIsp = 0;
    pulse_wd();
    chk("debugEnable erased", 1, debugEnable);
    $display("test security done");
    for (int k = 0; k < 4; k++) begin
      b = $urandom_range(EXT_INTS - 1);
      @(negedge mclk) powerDown = 1;
      extIntWakeEn = k[0] ? '0 : EXT_INTS'(1) << b;
      extIntPins[b] = 1;
      n = 0;
      repeat (8) @(negedge mclk) n += (wakeUp === 1'b1);
      chk("wakeUp", !k[0], n > 0);
      chk("extIntFlags", 1, extIntFlags[b]);
      extIntPins = 0;
      powerDown = 0;
      repeat (4) @(negedge mclk);
    end
    $display("test wake done");
    end_of_test();
  end
endmodule : test_system_reset_and_supply_monitor
`default_nettype wire
